// ---- crs_pkg.sv ----
// package: constants and types for the cpu register set
package crs_pkg;
	localparam int unsigned CRS_XLEN = 32;
	localparam int unsigned CRS_NGPR = 32;
	localparam logic [4:0] CRS_GPR_ZERO = 5'h00;
	localparam logic [4:0] CRS_GPR_STR_DST_OFS = 5'h1a;
	localparam logic [4:0] CRS_GPR_STR_SRC_OFS = 5'h1b;
	localparam logic [4:0] CRS_GPR_STR_LEN = 5'h1c;
	localparam logic [4:0] CRS_GPR_STR_DST = 5'h1d;
	localparam logic [4:0] CRS_GPR_STR_SRC = 5'h1e;
	localparam logic [4:0] CRS_GPR_LINK = 5'h1f;
	// system register numbers
	localparam logic [4:0] CRS_SR_EXC_PC = 5'h00;
	localparam logic [4:0] CRS_SR_EXC_PSW = 5'h01;
	localparam logic [4:0] CRS_SR_FAT_PC = 5'h02;
	localparam logic [4:0] CRS_SR_FAT_PSW = 5'h03;
	localparam logic [4:0] CRS_SR_CAUSE = 5'h04;
	localparam logic [4:0] CRS_SR_PSW = 5'h05;
	localparam logic [4:0] CRS_SR_IDENT = 5'h06;
	localparam logic [4:0] CRS_SR_FPCTL = 5'h07;
	localparam logic [4:0] CRS_SR_ICCTL = 5'h18;
	localparam logic [4:0] CRS_SR_TRAP = 5'h19;
	// cause register halves
	localparam int unsigned CRS_CAUSE_HALF = 16;
	localparam int unsigned CRS_CAUSE_FAT_LSB = 16;
	// reset values
	localparam logic [31:0] CRS_PC_RESET = 32'h0ffffff0;
	localparam logic [31:0] CRS_ZERO = 32'h00000000;
	// gpr write port group
	typedef struct packed {
		logic en;
		logic [4:0] idx;
		logic [31:0] data;
	} crs_gwr_s;
	// event save request
	typedef struct packed {
		logic exc;
		logic fat;
		logic [15:0] code;
	} crs_evt_s;
	// state
	typedef struct packed {
		logic [31:0] pc;
		logic [31:0] exc_pc;
		logic [31:0] exc_psw;
		logic [31:0] fat_pc;
		logic [31:0] fat_psw;
		logic [15:0] fat_code;
		logic [15:0] exc_code;
		logic [31:0] program_status_word;
		logic [31:0] fpctl;
		logic [31:0] icctl;
		logic [31:0] trap;
		logic [31:0] srd;
	} crs_st_s;
endpackage

// ---- crs_regset.sv ----
// cpu register set: general registers, program counter and system registers
//
// Contract
// - every gpr, the pc and every system register is 32 bits wide
// - thirty-two gprs, 0 to 31, usable as data or address operands
// - gprs 0 and 26 to 30 offered as implicit operands
// - string ops read fixed gprs 26 to 30 for offsets, length, addresses
// - jump-and-link writes the return address into gpr 31
// - pc bit 0 is always zero
// - reset loads the pc with 0ffffff0
// - exception or interrupt saves pc to sr0 and status to sr1
// - nmi or duplexed exception saves pc to sr2 and status to sr3
// - cause sr4: upper half fatal code, lower half exception code
// - sr5 holds the processor status flags
// - sr6 reads back the cpu type number
// - sr7 contents control floating point operations
// - sr24 contents control the instruction cache
// - sr25 holds a trap address; pc match redirects to fixed address
// - system registers reached only by load/store instructions by number
`timescale 1ns/1ps
`default_nettype none
module crs_regset
	import crs_pkg::*;
#(
	parameter logic [31:0] P_IDENT = 32'h00000a5a, // arbitrary type number
	parameter logic [31:0] P_TRAP_VECTOR = 32'hfffffe00
) (
	// clock and reset
	input wire logic I_CLK,
	input wire logic I_RSTN,
	// gpr read ports
	input wire logic [4:0] I_RA_IDX,
	input wire logic [4:0] I_RB_IDX,
	output logic [31:0] O_RA_DATA,
	output logic [31:0] O_RB_DATA,
	// gpr write port and link write
	input wire crs_gwr_s I_GWR,
	input wire logic I_JAL,
	input wire logic [31:0] I_JAL_RET,
	// implicit string and zero operands
	output logic [31:0] O_STR_DST_OFS,
	output logic [31:0] O_STR_SRC_OFS,
	output logic [31:0] O_STR_LEN,
	output logic [31:0] O_STR_DST,
	output logic [31:0] O_STR_SRC,
	output logic [31:0] O_ZERO,
	// program counter
	input wire logic I_PC_LD,
	input wire logic [31:0] I_PC_NEXT,
	output logic [31:0] O_PC,
	output logic O_TRAP_HIT,
	// system register load/store
	input wire logic I_SR_LOAD,
	input wire logic I_SR_STORE,
	input wire logic [4:0] I_SR_IDX,
	input wire logic [31:0] I_SR_WDATA,
	output logic [31:0] O_SR_RDATA,
	// events and status
	input wire crs_evt_s I_EVT,
	input wire logic I_PSW_WE,
	input wire logic [31:0] I_PSW_NEXT,
	output logic [31:0] O_PSW,
	output logic [31:0] O_FPCTL,
	output logic [31:0] O_ICCTL
);

////////////////////////////////////////////////////////////////////////////////

	logic [31:0] gpr_q [1:CRS_NGPR-1];
	crs_st_s st_q;
	crs_st_s st_d;

	// gpr 0 has no storage, reads are tied low
	function automatic logic [31:0] gpr_rd(input logic [4:0] idx);
		if (idx == CRS_GPR_ZERO) begin
			return CRS_ZERO;
		end
		return gpr_q[idx];
	endfunction

	assign O_RA_DATA = gpr_rd(I_RA_IDX);
	assign O_RB_DATA = gpr_rd(I_RB_IDX);
	assign O_ZERO = CRS_ZERO;
	assign O_STR_DST_OFS = gpr_q[CRS_GPR_STR_DST_OFS];
	assign O_STR_SRC_OFS = gpr_q[CRS_GPR_STR_SRC_OFS];
	assign O_STR_LEN = gpr_q[CRS_GPR_STR_LEN];
	assign O_STR_DST = gpr_q[CRS_GPR_STR_DST];
	assign O_STR_SRC = gpr_q[CRS_GPR_STR_SRC];

////////////////////////////////////////////////////////////////////////////////

	// link write takes priority over a plain write to the same cycle
	genvar gi;
	generate
		for (gi = 1; gi < CRS_NGPR; gi++) begin : g_gpr
			always_ff @(posedge I_CLK) begin
				if (!I_RSTN) begin
					gpr_q[gi] <= CRS_ZERO;
				end else if (I_JAL && gi == CRS_GPR_LINK) begin
					gpr_q[gi] <= I_JAL_RET;
				end else if (I_GWR.en && I_GWR.idx == gi) begin
					gpr_q[gi] <= I_GWR.data;
				end
			end
			// per register, so a write that lands in the wrong slot is caught too
			a_gpr_store: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
				I_GWR.en && I_GWR.idx == gi && !(I_JAL && gi == CRS_GPR_LINK)
				|=> gpr_q[gi] == $past(I_GWR.data)) else $error("gpr write lost");
			a_gpr_keep: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
				!(I_GWR.en && I_GWR.idx == gi) && !(I_JAL && gi == CRS_GPR_LINK)
				|=> $stable(gpr_q[gi])) else $error("gpr changed unasked");
		end
	endgenerate

////////////////////////////////////////////////////////////////////////////////

	function automatic logic sr_known(input logic [4:0] idx);
		return (idx <= CRS_SR_FPCTL) || (idx == CRS_SR_ICCTL) || (idx == CRS_SR_TRAP);
	endfunction

	logic trap_hit;
	logic sr_we;
	assign trap_hit = (st_q.pc == {st_q.trap[31:1], 1'b0});
	assign sr_we = I_SR_LOAD && sr_known(I_SR_IDX);

	always_comb begin
		st_d = st_q;
		// pipeline pc update, trap redirect wins
		if (trap_hit) begin
			st_d.pc = {P_TRAP_VECTOR[31:1], 1'b0};
		end else if (I_PC_LD) begin
			st_d.pc = {I_PC_NEXT[31:1], 1'b0};
		end
		if (I_PSW_WE) begin
			st_d.program_status_word = I_PSW_NEXT;
		end
		// software loads by number
		if (sr_we) begin
			case (I_SR_IDX)
				CRS_SR_EXC_PC: st_d.exc_pc = I_SR_WDATA;
				CRS_SR_EXC_PSW: st_d.exc_psw = I_SR_WDATA;
				CRS_SR_FAT_PC: st_d.fat_pc = I_SR_WDATA;
				CRS_SR_FAT_PSW: st_d.fat_psw = I_SR_WDATA;
				CRS_SR_PSW: st_d.program_status_word = I_SR_WDATA;
				CRS_SR_FPCTL: st_d.fpctl = I_SR_WDATA;
				CRS_SR_ICCTL: st_d.icctl = I_SR_WDATA;
				CRS_SR_TRAP: st_d.trap = I_SR_WDATA;
				default: st_d.srd = st_q.srd;
			endcase
		end
		// hardware saves override a software load in the same cycle
		if (I_EVT.exc) begin
			st_d.exc_pc = st_q.pc;
			st_d.exc_psw = st_q.program_status_word;
			st_d.exc_code = I_EVT.code;
		end
		if (I_EVT.fat) begin
			st_d.fat_pc = st_q.pc;
			st_d.fat_psw = st_q.program_status_word;
			st_d.fat_code = I_EVT.code;
		end
		// store read data registered; reserved numbers give zero
		st_d.srd = CRS_ZERO;
		if (I_SR_STORE) begin
			case (I_SR_IDX)
				CRS_SR_EXC_PC: st_d.srd = st_q.exc_pc;
				CRS_SR_EXC_PSW: st_d.srd = st_q.exc_psw;
				CRS_SR_FAT_PC: st_d.srd = st_q.fat_pc;
				CRS_SR_FAT_PSW: st_d.srd = st_q.fat_psw;
				CRS_SR_CAUSE: st_d.srd = {st_q.fat_code, st_q.exc_code};
				CRS_SR_PSW: st_d.srd = st_q.program_status_word;
				CRS_SR_IDENT: st_d.srd = P_IDENT;
				CRS_SR_FPCTL: st_d.srd = st_q.fpctl;
				CRS_SR_ICCTL: st_d.srd = st_q.icctl;
				CRS_SR_TRAP: st_d.srd = st_q.trap;
				default: st_d.srd = CRS_ZERO;
			endcase
		end
	end

	always_ff @(posedge I_CLK) begin
		if (!I_RSTN) begin
			st_q <= '0;
			st_q.pc <= CRS_PC_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	assign O_PC = st_q.pc;
	assign O_TRAP_HIT = trap_hit;
	assign O_SR_RDATA = st_q.srd;
	assign O_PSW = st_q.program_status_word;
	assign O_FPCTL = st_q.fpctl;
	assign O_ICCTL = st_q.icctl;

////////////////////////////////////////////////////////////////////////////////

	// general registers and implicit operands
	a_zero_read: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		I_RA_IDX == CRS_GPR_ZERO |-> O_RA_DATA == CRS_ZERO) else $error("gpr0 not zero");

	a_rb_zero: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		I_RB_IDX == CRS_GPR_ZERO |-> O_RB_DATA == CRS_ZERO)
		else $error("gpr0 not zero on port b");

	a_zero_port: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		O_ZERO == CRS_ZERO)
		else $error("zero operand not zero");

	a_str_dofs: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		I_GWR.en && I_GWR.idx == CRS_GPR_STR_DST_OFS |=> O_STR_DST_OFS == $past(I_GWR.data))
		else $error("string dest offset wrong");

	a_str_sofs: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		I_GWR.en && I_GWR.idx == CRS_GPR_STR_SRC_OFS |=> O_STR_SRC_OFS == $past(I_GWR.data))
		else $error("string source offset wrong");

	a_str_len: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		I_GWR.en && I_GWR.idx == CRS_GPR_STR_LEN |=> O_STR_LEN == $past(I_GWR.data))
		else $error("string length wrong");

	a_str_dst: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		I_GWR.en && I_GWR.idx == CRS_GPR_STR_DST |=> O_STR_DST == $past(I_GWR.data))
		else $error("string dest address wrong");

	a_str_src: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		I_GWR.en && I_GWR.idx == CRS_GPR_STR_SRC |=> O_STR_SRC == $past(I_GWR.data))
		else $error("string source address wrong");

	a_link_write: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		I_JAL ##1 (I_RA_IDX == CRS_GPR_LINK) |-> O_RA_DATA == $past(I_JAL_RET))
		else $error("link not written");

	a_link_prio: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		I_JAL && I_GWR.en && I_GWR.idx == CRS_GPR_LINK |=> gpr_q[CRS_GPR_LINK] == $past(I_JAL_RET))
		else $error("link lost to plain write");

	// program counter and reset
	a_pc_even: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		O_PC[0] == 1'b0) else $error("pc bit 0 set");

	a_pc_load: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		I_PC_LD && !O_TRAP_HIT |=> O_PC == {$past(I_PC_NEXT[31:1]), 1'b0})
		else $error("pc load wrong");

	a_pc_hold: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		!I_PC_LD && !O_TRAP_HIT |=> $stable(O_PC))
		else $error("pc moved unasked");

	a_pc_reset: assert property (@(posedge I_CLK)
		!I_RSTN |=> O_PC == CRS_PC_RESET) else $error("pc reset value wrong");

	a_reset_clear: assert property (@(posedge I_CLK)
		!I_RSTN |=> O_SR_RDATA == CRS_ZERO && O_PSW == CRS_ZERO)
		else $error("state not cleared by reset");

	// event saves and cause
	a_exc_save: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		I_EVT.exc |=> st_q.exc_pc == $past(O_PC) && st_q.exc_psw == $past(O_PSW))
		else $error("exception save wrong");

	a_exc_store: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		I_SR_STORE && I_SR_IDX == CRS_SR_EXC_PC |=> O_SR_RDATA == $past(st_q.exc_pc))
		else $error("exception pc read wrong");

	a_fat_save: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		I_EVT.fat |=> st_q.fat_pc == $past(O_PC) && st_q.fat_code == $past(I_EVT.code))
		else $error("fatal save wrong");

	a_fat_psw: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		I_EVT.fat |=> st_q.fat_psw == $past(O_PSW))
		else $error("fatal status save wrong");

	a_fat_store: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		I_SR_STORE && I_SR_IDX == CRS_SR_FAT_PC |=> O_SR_RDATA == $past(st_q.fat_pc))
		else $error("fatal pc read wrong");

	a_cause_read: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		I_SR_STORE && I_SR_IDX == CRS_SR_CAUSE && !I_EVT.exc && !I_EVT.fat
		|=> O_SR_RDATA[15:0] == $past(st_q.exc_code)) else $error("cause low half wrong");

	a_cause_high: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		I_SR_STORE && I_SR_IDX == CRS_SR_CAUSE |=> O_SR_RDATA[31:16] == $past(st_q.fat_code))
		else $error("cause high half wrong");

	a_exc_code: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		I_EVT.exc |=> st_q.exc_code == $past(I_EVT.code))
		else $error("exception code not saved");

	// cause is read-only: only events may change it
	a_cause_keep: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		!I_EVT.exc && !I_EVT.fat |=> $stable({st_q.fat_code, st_q.exc_code}))
		else $error("cause changed without event");

	// status, identity and control words
	a_psw_update: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		I_PSW_WE && !(I_SR_LOAD && I_SR_IDX == CRS_SR_PSW) |=> O_PSW == $past(I_PSW_NEXT))
		else $error("status update lost");

	a_psw_load: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		I_SR_LOAD && I_SR_IDX == CRS_SR_PSW |=> O_PSW == $past(I_SR_WDATA))
		else $error("status load lost");

	a_psw_store: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		I_SR_STORE && I_SR_IDX == CRS_SR_PSW |=> O_SR_RDATA == $past(O_PSW))
		else $error("status read wrong");

	a_ident_read: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		I_SR_STORE && I_SR_IDX == CRS_SR_IDENT |=> O_SR_RDATA == P_IDENT)
		else $error("ident wrong");

	a_fpctl_load: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		I_SR_LOAD && I_SR_IDX == CRS_SR_FPCTL |=> O_FPCTL == $past(I_SR_WDATA))
		else $error("fp control not loaded");

	a_fpctl_store: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		I_SR_STORE && I_SR_IDX == CRS_SR_FPCTL |=> O_SR_RDATA == $past(O_FPCTL))
		else $error("fp control read wrong");

	a_icctl_load: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		I_SR_LOAD && I_SR_IDX == CRS_SR_ICCTL |=> O_ICCTL == $past(I_SR_WDATA))
		else $error("cache control not loaded");

	a_icctl_store: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		I_SR_STORE && I_SR_IDX == CRS_SR_ICCTL |=> O_SR_RDATA == $past(O_ICCTL))
		else $error("cache control read wrong");

	// address trap
	a_trap_load: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		I_SR_LOAD && I_SR_IDX == CRS_SR_TRAP |=> st_q.trap == $past(I_SR_WDATA))
		else $error("trap address not loaded");

	a_trap_jump: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		O_TRAP_HIT |=> O_PC == {P_TRAP_VECTOR[31:1], 1'b0}) else $error("trap not taken");

	// access by number only
	a_rdata_idle: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		!I_SR_STORE |=> O_SR_RDATA == CRS_ZERO)
		else $error("read data without store");

	a_no_load: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		!I_SR_LOAD && !I_EVT.exc && !I_EVT.fat
		|=> $stable(O_FPCTL) && $stable(O_ICCTL) && $stable(st_q.trap)
		&& $stable(st_q.exc_pc) && $stable(st_q.fat_pc)) else $error("sr changed without load");

	a_reserved_zero: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		I_SR_STORE && !sr_known(I_SR_IDX) && I_SR_IDX != CRS_SR_CAUSE
		&& I_SR_IDX != CRS_SR_IDENT |=> O_SR_RDATA == CRS_ZERO)
		else $error("reserved sr not zero");

	a_reserved_load: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		I_SR_LOAD && !sr_known(I_SR_IDX)
		|=> $stable(O_FPCTL) && $stable(O_ICCTL) && $stable(st_q.trap))
		else $error("reserved load had effect");

endmodule
`default_nettype wire

// ---- crs_pipe_model.sv ----
// pipeline model: issues register set requests, one cycle each
`timescale 1ns/1ps
`default_nettype none
module crs_pipe_model
	import crs_pkg::*;
(
	// clock
	input wire logic i_clk,
	// requests to the register set
	output crs_gwr_s o_gwr,
	output logic o_jal,
	output logic [31:0] o_jal_ret,
	output logic o_pc_ld,
	output logic [31:0] o_pc_nx,
	output logic o_ld,
	output logic o_st,
	output logic [4:0] o_idx,
	output logic [31:0] o_wd,
	output crs_evt_s o_evt,
	output logic o_psw_we,
	output logic [31:0] o_psw_nx
);
	////////////////////////////////////////
	initial begin
		{o_gwr, o_jal, o_jal_ret, o_pc_ld, o_pc_nx, o_ld, o_st} = '0;
		{o_idx, o_wd, o_evt, o_psw_we, o_psw_nx} = '0;
	end
	// strobes drop after one edge; gpr and sr write data invert so a stale value never passes
	task automatic fin();
		@(negedge i_clk);
		{o_gwr.en, o_jal, o_pc_ld, o_ld, o_st, o_evt.exc, o_evt.fat, o_psw_we} = 8'h00;
		o_gwr.data = ~o_gwr.data;
		o_wd = ~o_wd;
	endtask
	task automatic gwr(input logic [4:0] i, input logic [31:0] d, input logic j);
		o_gwr = '{1'b1, i, d};
		o_jal = j;
		o_jal_ret = ~d;
		fin();
	endtask
	task automatic sr(input logic ld, input logic [4:0] i, input logic [31:0] d);
		o_ld = ld;
		o_st = !ld;
		o_idx = i;
		o_wd = d;
		fin();
	endtask
	task automatic ev(input logic [1:0] k, input logic [15:0] c);
		{o_evt.exc, o_evt.fat} = k;
		o_evt.code = c;
		fin();
	endtask
	// w high updates the status word, low loads the pc
	task automatic up(input logic w, input logic [31:0] d);
		o_pc_ld = !w;
		o_pc_nx = d;
		o_psw_we = w;
		o_psw_nx = d;
		fin();
	endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
// testbench for the cpu register set
`timescale 1ns/1ps
`default_nettype none
module testbench
	import crs_pkg::*;
;
	localparam logic [31:0] TB_IDENT = 32'h00001234; // arbitrary type number
	localparam logic [31:0] TB_VEC = 32'h00000400;
	logic clk, rstn, jump_and_link_instr, pld, sld, st, pwe, hit, st_d;
	logic [4:0] ra, rb, sidx;
	logic [31:0] rda, rdb, pc, srd, program_status_word, fpc, icc, zo, jret, pnx, swd, pwnx, v, pcv;
	logic [31:0] so [5];
	logic [31:0] g [32];
	logic [31:0] e [32];
	logic [31:0] q [$];
	logic [31:0] seed = 32'h0000b604;
	crs_gwr_s gwr;
	crs_evt_s evt;
	int fail_count = 0;
	int checks = 0;
	////////////////////////////////////////
	crs_regset #(.P_IDENT(TB_IDENT), .P_TRAP_VECTOR(TB_VEC)) uut (.I_CLK(clk), .I_RSTN(rstn),
		.I_RA_IDX(ra), .I_RB_IDX(rb), .O_RA_DATA(rda), .O_RB_DATA(rdb), .I_GWR(gwr),
		.I_JAL(jump_and_link_instr), .I_JAL_RET(jret), .O_STR_DST_OFS(so[0]), .O_STR_SRC_OFS(so[1]),
		.O_STR_LEN(so[2]), .O_STR_DST(so[3]), .O_STR_SRC(so[4]), .O_ZERO(zo),
		.I_PC_LD(pld), .I_PC_NEXT(pnx), .O_PC(pc), .O_TRAP_HIT(hit), .I_SR_LOAD(sld),
		.I_SR_STORE(st), .I_SR_IDX(sidx), .I_SR_WDATA(swd), .O_SR_RDATA(srd), .I_EVT(evt),
		.I_PSW_WE(pwe), .I_PSW_NEXT(pwnx), .O_PSW(program_status_word), .O_FPCTL(fpc), .O_ICCTL(icc));
	crs_pipe_model pm (.i_clk(clk), .o_gwr(gwr), .o_jal(jump_and_link_instr), .o_jal_ret(jret),
		.o_pc_ld(pld), .o_pc_nx(pnx), .o_ld(sld), .o_st(st), .o_idx(sidx), .o_wd(swd),
		.o_evt(evt), .o_psw_we(pwe), .o_psw_nx(pwnx));
	////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// read every system register number; results are judged by the watcher
	task automatic rd_all();
		for (int i = 0; i < 32; i++) begin
			q.push_back(e[i]);
			pm.sr(1'b0, i[4:0], 32'h0);
		end
	endtask
	// watcher: read data stands one cycle after a store, zero otherwise
	always @(posedge clk) st_d <= st & rstn;
	always @(negedge clk) begin
		if (st_d)
			chk("sr_rdata", srd, q.pop_front());
		else
			chk("sr_idle", srd, 32'h0);
	end
	initial begin
		repeat (2000) @(posedge clk);
		fail_count++;
		close_out();
	end
	////////////////////////////////////////
	initial begin
		rstn = 1'b0;
		ra = 5'h00;
		rb = 5'h00;
		repeat (6) @(posedge clk);
		@(negedge clk);
		chk("pc_rst", pc, CRS_PC_RESET);
		rstn = 1'b1;
		@(negedge clk);
		for (int i = 0; i < 32; i++) begin
			v = rnd();
			g[i] = (i == 0) ? 32'h0 : v;
			pm.gwr(i[4:0], v, 1'b0);
		end
		v = rnd();
		ra = CRS_GPR_LINK;
		pm.gwr(CRS_GPR_LINK, v, 1'b1);
		g[31] = ~v;
		for (int i = 0; i < 32; i++) begin
			@(negedge clk);
			ra = i[4:0];
			rb = ~i[4:0];
			#1;
			chk("gpr_a", rda, g[i]);
			chk("gpr_b", rdb, g[31 - i]);
		end
		for (int k = 0; k < 5; k++) chk("str", so[k], g[26 + k]);
		chk("zero", zo, 32'h0);
		$display("test gpr done");
		v = rnd();
		pcv = {v[31:1], 1'b0};
		pm.up(1'b0, v | 32'h1);
		chk("pc_ld", pc, pcv);
		for (int i = 0; i < 32; i++) begin
			v = rnd();
			e[i] = (i == 6) ? TB_IDENT : 32'h0;
			if (i inside {[0:3], 5, 7, 24, 25}) e[i] = v;
			pm.sr(1'b1, i[4:0], v);
		end
		rd_all();
		chk("psw", program_status_word, e[5]);
		chk("fpctl", fpc, e[7]);
		chk("icctl", icc, e[24]);
		$display("test sysreg done");
		v = rnd();
		pm.up(1'b1, v);
		e[5] = v;
		v = rnd();
		pm.ev(2'b10, v[15:0]);
		e[0] = pcv;
		e[1] = e[5];
		e[4][15:0] = v[15:0];
		v = rnd();
		pm.ev(2'b01, v[15:0]);
		e[2] = pcv;
		e[3] = e[5];
		e[4][31:16] = v[15:0];
		rd_all();
		$display("test events done");
		pm.sr(1'b1, CRS_SR_TRAP, pcv);
		chk("hit", {31'h0, hit}, 32'h1);
		@(negedge clk);
		chk("pc_trap", pc, TB_VEC);
		$display("test trap done");
		close_out();
	end
endmodule
`default_nettype wire
